// *** core/bcid_core.sv ***
// Purpose: decode and execute a subset of the byte-core instruction set
// Assumes: instruction words arrive on a valid/ready handshake
// Notes: one instruction cycle is two clocks, fetch then execute
`timescale 1ns/100ps
`include "bcid_defines.svh"
// Notes on behaviour
// RULE_01: add accumulator, file and carry; three flags
// RULE_02: OR accumulator with file, d selects destination
// RULE_03: rotate file left through carry, only C
// RULE_04: rotate file right through carry, only C
// RULE_05: file minus accumulator minus borrow, three flags
// RULE_06: XOR accumulator with file, zero flag only
// RULE_07: decrement file, skip next when zero
// RULE_08: increment file, skip when zero, no flags
// RULE_09: skip next when selected bit is clear
// RULE_10: skip next when selected bit is set
// RULE_11: OR literal into accumulator, zero flag
// RULE_12: literal seven bits into code page latch
// RULE_13: literal minus accumulator into accumulator, three flags
// RULE_14: XOR literal into accumulator in one cycle
// RULE_15: skips take a second, no-operation cycle
// RULE_16: indirect with pointer top bit adds cycle
// RULE_17: low seven bits address, bit 7 destination
// RULE_18: zero flag set exactly when result zero
module bcid_core (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  output logic instr_ready_o,
  output logic retire_o,
  output logic [7:0] acc_o,
  output bcid_pkg::bcid_flags_t flags_o,
  output logic [6:0] program_counter_high_latch_o
);
  import bcid_pkg::*;

  bcid_state_t state_q;
  bcid_state_t state_d;
  logic [13:0] instr_q;
  logic [6:0] eff_q;
  logic [1:0] ind_cnt_q;
  logic skip_q;
  logic [7:0] ptr_q [4];
  logic [7:0] mem_rdata;
  logic accept;
  logic [6:0] eff_d;
  logic ind_slow_d;
  bcid_op_t cur_op;
  logic [7:0] file_val;
  logic [7:0] alu_b;
  bcid_alu_res_t alu_res;
  logic acc_wr;
  logic file_wr;
  logic in_exec;

  function automatic bcid_op_t decode_op(input logic [13:0] w);
    decode_op = OP_NONE;
    case (w[13:8])
      `BCID_OPC_ADD_ACC_FILE_CARRY: decode_op = OP_ADD_ACC_FILE_CARRY;
      `BCID_OPC_OR_ACC_FILE: decode_op = OP_OR_ACC_FILE;
      `BCID_OPC_ROTATE_LEFT_CARRY: decode_op = OP_ROTATE_LEFT_CARRY;
      `BCID_OPC_ROTATE_RIGHT_CARRY: decode_op = OP_ROTATE_RIGHT_CARRY;
      `BCID_OPC_SUB_FILE_BORROW: decode_op = OP_SUB_FILE_BORROW;
      `BCID_OPC_XOR_ACC_FILE: decode_op = OP_XOR_ACC_FILE;
      `BCID_OPC_DEC_SKIP_ZERO: decode_op = OP_DEC_SKIP_ZERO;
      `BCID_OPC_INC_SKIP_ZERO: decode_op = OP_INC_SKIP_ZERO;
      `BCID_OPC_OR_LITERAL_ACC: decode_op = OP_OR_LITERAL_ACC;
      `BCID_OPC_SUB_ACC_FROM_LITERAL:
        decode_op = OP_SUB_ACC_FROM_LITERAL;
      `BCID_OPC_XOR_LITERAL_ACC: decode_op = OP_XOR_LITERAL_ACC;
      `BCID_OPC_LOAD_CODE_PAGE:
        if (w[7])
          decode_op = OP_LOAD_CODE_PAGE; // [RULE_12]
      default:
      begin
        if (w[13:10] == `BCID_OPC_BIT_TEST_SKIP_CLEAR)
          decode_op = OP_BIT_TEST_SKIP_CLEAR;
        else if (w[13:10] == `BCID_OPC_BIT_TEST_SKIP_SET)
          decode_op = OP_BIT_TEST_SKIP_SET;
      end
    endcase
  endfunction

  function automatic logic is_file_op(input bcid_op_t op);
    case (op)
      OP_NONE, OP_OR_LITERAL_ACC, OP_LOAD_CODE_PAGE,
      OP_SUB_ACC_FROM_LITERAL, OP_XOR_LITERAL_ACC:
        is_file_op = 1'b0;
      default:
        is_file_op = 1'b1;
    endcase
  endfunction

  // pointer bytes sit as flip-flops so indirection needs no extra read
  function automatic logic is_ptr_addr(input logic [6:0] a);
    is_ptr_addr = (a[6:2] == `BCID_PTR_BASE);
  endfunction

  assign accept = instr_valid_i && instr_ready_o;
  assign cur_op = decode_op(instr_q);
  assign in_exec = (state_q == S_EXEC);

  // effective file address, resolved at fetch
  always_comb
  begin
    eff_d = instr_i[6:0]; // [RULE_17]
    ind_slow_d = 1'b0;
    if (is_file_op(decode_op(instr_i)))
    begin
      if (instr_i[6:0] == `BCID_IND0_ADDR)
      begin
        eff_d = ptr_q[`BCID_PTR0_LO][6:0];
        ind_slow_d = ptr_q[`BCID_PTR0_HI][7]; // [RULE_16]
      end
      else if (instr_i[6:0] == `BCID_IND1_ADDR)
      begin
        eff_d = ptr_q[`BCID_PTR1_LO][6:0];
        ind_slow_d = ptr_q[`BCID_PTR1_HI][7]; // [RULE_16]
      end
    end
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_FETCH:
        if (accept)
        begin
          if (skip_q)
            state_d = S_DISCARD; // [RULE_15]
          else if (ind_slow_d)
            state_d = S_IND; // [RULE_16]
          else
            state_d = S_EXEC;
        end
      S_IND:
        if (ind_cnt_q == `BCID_IND_CLKS - 2'h1)
          state_d = S_EXEC;
      S_EXEC:
        state_d = S_FETCH;
      S_DISCARD:
        state_d = S_FETCH;
      default:
        state_d = S_FETCH;
    endcase
  end

  bcid_file_mem u_file (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .en_i(en_i),
    .rd_en_i(accept),
    .rd_addr_i(eff_d),
    .wr_en_i(file_wr && !is_ptr_addr(eff_q)),
    .wr_addr_i(eff_q),
    .wr_data_i(alu_res.value),
    .rd_data_o(mem_rdata)
  );

  assign file_val = is_ptr_addr(eff_q) ? ptr_q[eff_q[1:0]] : mem_rdata;
  assign alu_b = is_file_op(cur_op) ? file_val : instr_q[7:0];

  bcid_alu u_alu (
    .op_i(cur_op),
    .acc_i(acc_o),
    .b_i(alu_b),
    .carry_i(flags_o.carry),
    .bit_sel_i(instr_q[`BCID_BIT_SEL_HI:`BCID_BIT_SEL_LO]),
    .res_o(alu_res)
  );

  // destination: literal ops always the accumulator, file ops by d
  assign acc_wr = in_exec && alu_res.writes &&
                  (!is_file_op(cur_op) || !instr_q[`BCID_DEST_BIT]);
  assign file_wr = in_exec && alu_res.writes && is_file_op(cur_op) &&
                   instr_q[`BCID_DEST_BIT]; // [RULE_17]

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= S_FETCH;
      instr_ready_o <= 1'b1;
      retire_o <= 1'b0;
    end
    else if (en_i)
    begin
      state_q <= state_d;
      instr_ready_o <= (state_d == S_FETCH);
      retire_o <= in_exec || (state_q == S_DISCARD);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      instr_q <= 14'h0000;
      eff_q <= 7'h00;
    end
    else if (en_i && accept)
    begin
      instr_q <= instr_i;
      eff_q <= eff_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ind_cnt_q <= 2'h0;
    else if (en_i)
      ind_cnt_q <= (state_q == S_IND) ? ind_cnt_q + 2'h1 : 2'h0;
  end

  // the word after a taken skip is consumed as a no-operation
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      skip_q <= 1'b0;
    else if (en_i)
    begin
      if (in_exec)
        skip_q <= alu_res.skip; // [RULE_07] [RULE_08] [RULE_09] [RULE_10]
      else if (state_q == S_DISCARD)
        skip_q <= 1'b0; // [RULE_15]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      acc_o <= 8'h00;
    else if (en_i && acc_wr)
      acc_o <= alu_res.value; // [RULE_11] [RULE_13] [RULE_14]
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      flags_o <= '0;
    else if (en_i && in_exec)
    begin
      if (alu_res.upd.carry)
        flags_o.carry <= alu_res.flags.carry; // [RULE_03] [RULE_04]
      if (alu_res.upd.digit_carry_flag)
        flags_o.digit_carry_flag <= alu_res.flags.digit_carry_flag;
      if (alu_res.upd.zero)
        flags_o.zero <= alu_res.flags.zero; // [RULE_18]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      program_counter_high_latch_o <= 7'h00;
    else if (en_i && in_exec && cur_op == OP_LOAD_CODE_PAGE)
      program_counter_high_latch_o <= instr_q[6:0]; // [RULE_12]
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ptr_q <= '{default: 8'h00};
    else if (en_i && file_wr && is_ptr_addr(eff_q))
      ptr_q[eff_q[1:0]] <= alu_res.value;
  end

  // checks sample only enabled edges, so a frozen core never trips them
  default clocking cb @(posedge clk_i iff en_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_exec(bcid_op_t op);
    state_q == S_EXEC && cur_op == op;
  endsequence

  sequence s_discard_slot;
    state_q == S_DISCARD ##1 (retire_o && instr_ready_o);
  endsequence

  a_ready_after_exec: assert property ( // [RULE_15]
    state_q == S_EXEC |=> instr_ready_o && retire_o)
    else $error("ready not restored after execute");

  a_skip_discard: assert property ( // [RULE_15]
    (accept && skip_q) |=> s_discard_slot ##0 $stable(acc_o))
    else $error("skipped word was not a no-operation");

  a_ind_extra_cycle: assert property ( // [RULE_16]
    (accept && !skip_q && ind_slow_d) |=>
      !instr_ready_o [*3] ##1 instr_ready_o)
    else $error("indirect access lacks extra cycle");

  a_plain_two_clocks: assert property ( // [RULE_16]
    (accept && !skip_q && !ind_slow_d) |=> !instr_ready_o ##1 instr_ready_o)
    else $error("instruction cycle length wrong");

  a_zero_flag: assert property ( // [RULE_18]
    (in_exec && alu_res.upd.zero) |=>
      flags_o.zero == ($past(alu_res.value) == 8'h00))
    else $error("zero flag disagrees with result");

  a_rot_left: assert property ( // [RULE_03]
    s_exec(OP_ROTATE_LEFT_CARRY) |=>
      flags_o.carry == $past(alu_b[7]) && $stable(flags_o.zero))
    else $error("left rotate carry wrong");

  a_rot_right: assert property ( // [RULE_04]
    s_exec(OP_ROTATE_RIGHT_CARRY) |=>
      flags_o.carry == $past(alu_b[0]) && $stable(flags_o.zero))
    else $error("right rotate carry wrong");

  a_page_load: assert property ( // [RULE_12]
    (accept && !skip_q && decode_op(instr_i) == OP_LOAD_CODE_PAGE) |=>
      ##1 program_counter_high_latch_o == $past(instr_i[6:0], 2) &&
      $stable(flags_o))
    else $error("code page latch not loaded");

  a_dec_skip: assert property ( // [RULE_07]
    (s_exec(OP_DEC_SKIP_ZERO) ##0 alu_b == 8'h01) |=> skip_q)
    else $error("decrement to zero did not skip");

  a_inc_no_flags: assert property ( // [RULE_08]
    s_exec(OP_INC_SKIP_ZERO) |=> $stable(flags_o))
    else $error("increment-skip changed flags");
endmodule

// *** core/bcid_defines.svh ***
// Purpose: opcode fields, special file addresses and cycle counts
// Assumes: fourteen-bit instruction words
// Notes: definitions only
`ifndef BCID_DEFINES_SVH
`define BCID_DEFINES_SVH

// six-bit major opcode fields, instruction bits 13:8
`define BCID_OPC_ADD_ACC_FILE_CARRY 6'h3d
`define BCID_OPC_OR_ACC_FILE 6'h04
`define BCID_OPC_ROTATE_LEFT_CARRY 6'h0d
`define BCID_OPC_ROTATE_RIGHT_CARRY 6'h0c
`define BCID_OPC_SUB_FILE_BORROW 6'h3b
`define BCID_OPC_XOR_ACC_FILE 6'h06
`define BCID_OPC_DEC_SKIP_ZERO 6'h0b
`define BCID_OPC_INC_SKIP_ZERO 6'h0f
`define BCID_OPC_OR_LITERAL_ACC 6'h38
`define BCID_OPC_SUB_ACC_FROM_LITERAL 6'h3c
`define BCID_OPC_XOR_LITERAL_ACC 6'h3a
`define BCID_OPC_LOAD_CODE_PAGE 6'h31
// four-bit fields, instruction bits 13:10
`define BCID_OPC_BIT_TEST_SKIP_CLEAR 4'h6
`define BCID_OPC_BIT_TEST_SKIP_SET 4'h7

// operand field positions
`define BCID_DEST_BIT 7
`define BCID_BIT_SEL_HI 9
`define BCID_BIT_SEL_LO 7

// file addresses of the indirect registers and their pointers
`define BCID_IND0_ADDR 7'h00
`define BCID_IND1_ADDR 7'h01
`define BCID_PTR_BASE 5'h01
`define BCID_PTR0_LO 2'h0
`define BCID_PTR0_HI 2'h1
`define BCID_PTR1_LO 2'h2
`define BCID_PTR1_HI 2'h3

// one extra instruction cycle for indirect access, in clocks
`define BCID_IND_CLKS 2'h2
`define BCID_FILE_WORDS 128

`endif

// *** core/bcid_pkg.sv ***
// Purpose: shared types of the instruction decoder
// Assumes: nothing
// Notes: numbers live in bcid_defines.svh
package bcid_pkg;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_ADD_ACC_FILE_CARRY,
    OP_OR_ACC_FILE,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_SUB_FILE_BORROW,
    OP_XOR_ACC_FILE,
    OP_DEC_SKIP_ZERO,
    OP_INC_SKIP_ZERO,
    OP_BIT_TEST_SKIP_CLEAR,
    OP_BIT_TEST_SKIP_SET,
    OP_OR_LITERAL_ACC,
    OP_LOAD_CODE_PAGE,
    OP_SUB_ACC_FROM_LITERAL,
    OP_XOR_LITERAL_ACC
  } bcid_op_t;

  typedef enum logic [1:0] {
    S_FETCH,
    S_IND,
    S_EXEC,
    S_DISCARD
  } bcid_state_t;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } bcid_flags_t;

  typedef struct packed {
    logic [7:0] value;
    bcid_flags_t flags;
    bcid_flags_t upd;
    logic writes;
    logic skip;
  } bcid_alu_res_t;

endpackage

// *** core/bcid_alu.sv ***
// Purpose: result, flags and skip decision for one instruction
// Assumes: operand b is the file value or the literal
// Notes: purely combinational
`timescale 1ns/100ps
`include "bcid_defines.svh"
module bcid_alu (
  input wire bcid_pkg::bcid_op_t op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] b_i,
  input wire logic carry_i,
  input wire logic [2:0] bit_sel_i,
  output bcid_pkg::bcid_alu_res_t res_o
);
  import bcid_pkg::*;

  // returns {digit carry, carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic ci);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    add8 = {lo[4], full[8], full[7:0]};
  endfunction

  always_comb
  begin
    logic [9:0] sum;
    sum = 10'h000;
    res_o = '0;
    case (op_i)
      OP_ADD_ACC_FILE_CARRY:
      begin
        sum = add8(acc_i, b_i, carry_i); // [RULE_01]
        res_o.value = sum[7:0];
        res_o.flags = {sum[8], sum[9], sum[7:0] == 8'h00}; // [RULE_18]
        res_o.upd = 3'b111;
        res_o.writes = 1'b1;
      end
      OP_SUB_FILE_BORROW:
      begin
        // carry set means no borrow, so it feeds the sum directly
        sum = add8(b_i, ~acc_i, carry_i); // [RULE_05]
        res_o.value = sum[7:0];
        res_o.flags = {sum[8], sum[9], sum[7:0] == 8'h00};
        res_o.upd = 3'b111;
        res_o.writes = 1'b1;
      end
      OP_SUB_ACC_FROM_LITERAL:
      begin
        sum = add8(b_i, ~acc_i, 1'b1); // [RULE_13]
        res_o.value = sum[7:0];
        res_o.flags = {sum[8], sum[9], sum[7:0] == 8'h00};
        res_o.upd = 3'b111;
        res_o.writes = 1'b1;
      end
      OP_OR_ACC_FILE, OP_OR_LITERAL_ACC:
      begin
        res_o.value = acc_i | b_i; // [RULE_02] [RULE_11]
        res_o.flags.zero = (res_o.value == 8'h00);
        res_o.upd = 3'b001;
        res_o.writes = 1'b1;
      end
      OP_XOR_ACC_FILE, OP_XOR_LITERAL_ACC:
      begin
        res_o.value = acc_i ^ b_i; // [RULE_06] [RULE_14]
        res_o.flags.zero = (res_o.value == 8'h00);
        res_o.upd = 3'b001;
        res_o.writes = 1'b1;
      end
      OP_ROTATE_LEFT_CARRY:
      begin
        res_o.value = {b_i[6:0], carry_i}; // [RULE_03]
        res_o.flags.carry = b_i[7];
        res_o.upd = 3'b100;
        res_o.writes = 1'b1;
      end
      OP_ROTATE_RIGHT_CARRY:
      begin
        res_o.value = {carry_i, b_i[7:1]}; // [RULE_04]
        res_o.flags.carry = b_i[0];
        res_o.upd = 3'b100;
        res_o.writes = 1'b1;
      end
      OP_DEC_SKIP_ZERO:
      begin
        res_o.value = b_i - 8'h01; // [RULE_07]
        res_o.skip = (res_o.value == 8'h00);
        res_o.writes = 1'b1;
      end
      OP_INC_SKIP_ZERO:
      begin
        res_o.value = b_i + 8'h01; // [RULE_08]
        res_o.skip = (res_o.value == 8'h00);
        res_o.writes = 1'b1;
      end
      OP_BIT_TEST_SKIP_CLEAR:
        res_o.skip = ~b_i[bit_sel_i]; // [RULE_09]
      OP_BIT_TEST_SKIP_SET:
        res_o.skip = b_i[bit_sel_i]; // [RULE_10]
      default:
        res_o = '0;
    endcase
  end
endmodule

// *** core/bcid_file_mem.sv ***
// Purpose: 128-byte data file with registered read data
// Assumes: one read and one write port, same clock
// Notes: contents are not reset
`timescale 1ns/100ps
`include "bcid_defines.svh"
module bcid_file_mem (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic rd_en_i,
  input wire logic [6:0] rd_addr_i,
  input wire logic wr_en_i,
  input wire logic [6:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem_q [`BCID_FILE_WORDS];

  always_ff @(posedge clk_i)
  begin
    if (en_i && wr_en_i)
      mem_q[wr_addr_i] <= wr_data_i;
  end

  // read data holds between reads so waits can reuse it
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rd_data_o <= 8'h00;
    else if (en_i && rd_en_i)
      rd_data_o <= mem_q[rd_addr_i];
  end
endmodule

// *** test/bcid_prog_mem.sv ***
// Purpose: program memory model that offers instruction words
// Assumes: a word is taken at a rising edge with valid, ready and en high
// Notes: a released bus shows the inverse of the last word
`timescale 1ns/100ps
module bcid_prog_mem (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic instr_ready_i,
  input wire logic retire_i,
  output logic instr_valid_o,
  output logic [13:0] instr_o
);
  initial
  begin
    instr_valid_o = 1'b0;
    instr_o = 14'h0000;
  end

  // hold the word until taken, then count clocks up to retire
  task automatic send(input logic [13:0] word, output int clks);
    clks = 0;
    @(negedge clk_i);
    instr_valid_o = 1'b1;
    instr_o = word;
    do
      @(posedge clk_i);
    while (!(instr_ready_i === 1'b1 && en_i === 1'b1));
    @(negedge clk_i);
    instr_valid_o = 1'b0;
    // a stale copy would hide a core that samples too late
    instr_o = ~word;
    clks = 1;
    while (retire_i !== 1'b1 && clks < 16)
    begin
      @(negedge clk_i);
      clks++;
    end
  endtask
endmodule

// *** test/testbench.sv ***
// Purpose: self-checking bench of the instruction decoder
// Assumes: file bytes start unknown, so they are forced to ff first
// Notes: one instruction cycle is two clocks, indirect slow path four
`timescale 1ns/100ps
`include "bcid_defines.svh"
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end
module testbench;
  import bcid_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic en_i = 1'b1;
  logic instr_valid;
  logic [13:0] instr;
  logic instr_ready;
  logic retire;
  logic [7:0] acc;
  bcid_flags_t flags;
  logic [6:0] program_counter_high_latch;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #25 clk_i = ~clk_i;

  bcid_core i_bcid_core (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .en_i(en_i),
    .instr_valid_i(instr_valid),
    .instr_i(instr),
    .instr_ready_o(instr_ready),
    .retire_o(retire),
    .acc_o(acc),
    .flags_o(flags),
    .program_counter_high_latch_o(program_counter_high_latch)
  );

  bcid_prog_mem i_bcid_prog_mem (
    .clk_i(clk_i),
    .en_i(en_i),
    .instr_ready_i(instr_ready),
    .retire_i(retire),
    .instr_valid_o(instr_valid),
    .instr_o(instr)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // the tests need well under a thousand clocks
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end

  function automatic logic [9:0] addc(logic [7:0] x, logic [7:0] y,
                                      logic ci);
    logic [8:0] s;
    logic [4:0] n;
    s = x + y + ci;
    n = x[3:0] + y[3:0] + ci;
    return {s[8], n[4], s[7:0]};
  endfunction

  task automatic op_f(input logic [5:0] op, input logic d,
                      input logic [6:0] f, input int n_exp = 2);
    int n;
    i_bcid_prog_mem.send({op, d, f}, n);
    `CHK("clocks", n_exp, n)
  endtask

  task automatic op_l(input logic [5:0] op, input logic [7:0] k);
    op_f(op, k[7], k[6:0]);
  endtask

  task automatic chk_af(input logic [9:0] r);
    `CHK("acc", r[7:0], acc)
    `CHK("flags", {r[9], r[8], r[7:0] == 8'h00}, flags)
  endtask

  task automatic set_acc(input logic [7:0] k);
    op_l(`BCID_OPC_OR_LITERAL_ACC, 8'hff);
    op_l(`BCID_OPC_XOR_LITERAL_ACC, ~k);
  endtask

  // or with ff overrides the unknown reset-free contents
  task automatic set_file(input logic [6:0] a, input logic [7:0] v);
    op_l(`BCID_OPC_OR_LITERAL_ACC, 8'hff);
    op_f(`BCID_OPC_OR_ACC_FILE, 1'b1, a);
    op_l(`BCID_OPC_XOR_LITERAL_ACC, v);
    op_f(`BCID_OPC_XOR_ACC_FILE, 1'b1, a);
  endtask

  task automatic rd_file(input logic [6:0] a);
    set_acc(8'h00);
    op_f(`BCID_OPC_OR_ACC_FILE, 1'b0, a);
  endtask

  // leaves flags at {c, c, c}
  task automatic set_carry(input logic c);
    set_acc({7'h00, ~c});
    op_l(`BCID_OPC_SUB_ACC_FROM_LITERAL, 8'h00);
  endtask

  task automatic t_literal();
    logic [23:0] kl;
    logic [23:0] al;
    kl = 24'h100500;
    al = 24'h010501;
    set_acc(8'h0f);
    op_l(`BCID_OPC_OR_LITERAL_ACC, 8'h30);
    `CHK("or lit", 8'h3f, acc)
    `CHK("or lit zero", 1'b0, flags.zero)
    set_acc(8'h00);
    op_l(`BCID_OPC_OR_LITERAL_ACC, 8'h00);
    `CHK("or lit zero", 1'b1, flags.zero)
    set_acc(8'ha5);
    op_l(`BCID_OPC_XOR_LITERAL_ACC, 8'h3c);
    `CHK("xor lit", 8'h99, acc)
    for (int i = 0; i < 3; i++)
    begin
      set_acc(al[i*8+:8]);
      op_l(`BCID_OPC_SUB_ACC_FROM_LITERAL, kl[i*8+:8]);
      chk_af(addc(kl[i*8+:8], ~al[i*8+:8], 1'b1));
    end
    $display("test literal done");
  endtask

  task automatic t_file();
    set_file(7'h20, 8'h3c);
    set_acc(8'h41);
    op_f(`BCID_OPC_OR_ACC_FILE, 1'b1, 7'h20);
    `CHK("or dest file", 8'h41, acc)
    rd_file(7'h20);
    `CHK("or file", 8'h7d, acc)
    set_file(7'h21, 8'h5a);
    set_acc(8'h5a);
    op_f(`BCID_OPC_XOR_ACC_FILE, 1'b0, 7'h21);
    `CHK("xor file", 8'h00, acc)
    `CHK("xor zero", 1'b1, flags.zero)
    set_file(7'h22, 8'h01);
    set_carry(1'b1);
    op_f(`BCID_OPC_ROTATE_LEFT_CARRY, 1'b1, 7'h22);
    `CHK("rotl flags", 3'b011, flags)
    op_f(`BCID_OPC_ROTATE_RIGHT_CARRY, 1'b0, 7'h22);
    `CHK("rotr acc", 8'h01, acc)
    `CHK("rotr flags", 3'b111, flags)
    set_file(7'h23, 8'h8f);
    set_acc(8'h71);
    op_f(`BCID_OPC_ADD_ACC_FILE_CARRY, 1'b0, 7'h23);
    chk_af(addc(8'h71, 8'h8f, 1'b1));
    set_file(7'h24, 8'h10);
    set_acc(8'h10);
    op_f(`BCID_OPC_SUB_FILE_BORROW, 1'b1, 7'h24);
    `CHK("subb flags", 3'b111, flags)
    rd_file(7'h24);
    `CHK("subb file", 8'h00, acc)
    set_acc(8'h01);
    op_f(`BCID_OPC_SUB_FILE_BORROW, 1'b0, 7'h24);
    chk_af(addc(8'h00, 8'hfe, 1'b1));
    set_acc(8'h00);
    op_f(`BCID_OPC_SUB_FILE_BORROW, 1'b0, 7'h24);
    chk_af(addc(8'h00, 8'hff, 1'b0));
    $display("test file done");
  endtask

  task automatic t_skip();
    set_file(7'h30, 8'h01);
    set_acc(8'h00);
    op_f(`BCID_OPC_DEC_SKIP_ZERO, 1'b1, 7'h30);
    op_l(`BCID_OPC_XOR_LITERAL_ACC, 8'hff);
    `CHK("dec skip", 8'h00, acc)
    op_f(`BCID_OPC_DEC_SKIP_ZERO, 1'b1, 7'h30);
    op_l(`BCID_OPC_XOR_LITERAL_ACC, 8'hff);
    `CHK("dec no skip", 8'hff, acc)
    rd_file(7'h30);
    `CHK("dec file", 8'hff, acc)
    set_file(7'h31, 8'hff);
    set_carry(1'b0);
    op_f(`BCID_OPC_INC_SKIP_ZERO, 1'b1, 7'h31);
    `CHK("inc flags", 3'b000, flags)
    op_l(`BCID_OPC_XOR_LITERAL_ACC, 8'hff);
    `CHK("inc skip", 8'hff, acc)
    $display("test skip done");
  endtask

  task automatic t_bit_test();
    logic [2:0] b;
    logic [3:0] opc;
    logic skip;
    logic [7:0] e;
    set_file(7'h32, 8'h20);
    set_acc(8'h00);
    e = 8'h00;
    for (int i = 0; i < 16; i++)
    begin
      b = i[2:0];
      opc = i < 8 ? `BCID_OPC_BIT_TEST_SKIP_CLEAR
                  : `BCID_OPC_BIT_TEST_SKIP_SET;
      skip = (i < 8) ? (b != 3'h5) : (b == 3'h5);
      op_f({opc, b[2:1]}, b[0], 7'h32);
      op_l(`BCID_OPC_XOR_LITERAL_ACC, 8'hff);
      if (!skip)
        e = ~e;
      `CHK("bit test", e, acc)
    end
    rd_file(7'h32);
    `CHK("bit test file", 8'h20, acc)
    $display("test bit test done");
  endtask

  task automatic t_page();
    logic [20:0] kl;
    kl = {7'h7f, 7'h00, 7'h2a};
    set_acc(8'h5c);
    for (int i = 0; i < 3; i++)
    begin
      op_l(`BCID_OPC_LOAD_CODE_PAGE, {1'b1, kl[i*7+:7]});
      `CHK("code page", kl[i*7+:7], program_counter_high_latch)
      `CHK("code page acc", 8'h5c, acc)
    end
    // bit 7 clear is not a page load and must leave the latch alone
    op_f(`BCID_OPC_LOAD_CODE_PAGE, 1'b0, 7'h15);
    `CHK("code page bit7", 7'h7f, program_counter_high_latch)
    $display("test page done");
  endtask

  task automatic t_indirect();
    set_file(7'h40, 8'h6e);
    set_file({`BCID_PTR_BASE, `BCID_PTR0_LO}, 8'h40);
    set_file({`BCID_PTR_BASE, `BCID_PTR1_LO}, 8'h40);
    set_file({`BCID_PTR_BASE, `BCID_PTR1_HI}, 8'h80);
    set_acc(8'h00);
    op_f(`BCID_OPC_OR_ACC_FILE, 1'b0, `BCID_IND0_ADDR, 2);
    `CHK("indirect fast", 8'h6e, acc)
    set_acc(8'h00);
    op_f(`BCID_OPC_OR_ACC_FILE, 1'b0, `BCID_IND1_ADDR, 4);
    `CHK("indirect slow", 8'h6e, acc)
    $display("test indirect done");
  endtask

  // enable drops after the take, so the execute edge must wait for it
  task automatic t_enable();
    set_acc(8'h12);
    fork
      op_f(`BCID_OPC_OR_LITERAL_ACC, 1'b0, 7'h21, 5);
      begin
        repeat (2) @(negedge clk_i);
        en_i = 1'b0;
        repeat (3) @(negedge clk_i);
        `CHK("frozen acc", 8'h12, acc)
        en_i = 1'b1;
      end
    join
    `CHK("enable acc", 8'h33, acc)
    $display("test enable done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    t_literal();
    t_file();
    t_skip();
    t_bit_test();
    t_page();
    t_indirect();
    t_enable();
    finish_test();
  end
endmodule
